// ### design/sdd_top.v
// Purpose: Two-axis third-order sinc decimator for sigma-delta bitstreams
// Assumes: Bitstream inputs are synchronous to CLK and follow MOD_CLK
// Notes: Output words are raw two's complement sums, full scale +-4096
//   The dropped tick opens the last processing cycle before each modulator edge
//   The first three samples after reset, and the first, third and fifth after a change to ratio 8, are settling values; a change to ratio 16 adds none
// How it works
// - Two axes, separate datapaths, shared tick and bit strobe
// - One input bit per microsecond per axis
// - 8 MHz ticks, gated down to 6 MHz
// - Drop one tick before each modulator edge
// - Third-order sinc, length sixteen, serial to parallel
// - Output every 8 or 16 input bits
// - Four-bit select per axis picks ratio
`timescale 1ns/10ps
`default_nettype none
`include "sdd_regs.vh"

module sdd_top (
  input wire CLK, // System clock, 25 MHz
  input wire RST_N, // Synchronous reset, active low
  input wire X_BITSTREAM, // X modulator output bit
  input wire Y_BITSTREAM, // Y modulator output bit
  input wire [3:0] X_FILTER_SELECT, // X low-pass filter selection
  input wire [3:0] Y_FILTER_SELECT, // Y low-pass filter selection
  output reg MOD_CLK, // 1 MHz modulator clock
  output reg PROC_EN, // Gated processing tick, one-cycle pulse
  output wire [13:0] X_SAMPLE, // X decimated sample
  output wire X_VALID, // X sample strobe, one cycle
  output wire [13:0] Y_SAMPLE, // Y decimated sample
  output wire Y_VALID // Y sample strobe, one cycle
);

  // Selections with an even code run at 16 us, odd codes at 8 us
  function ratio_is_16;
    input [`SDD_SEL_W-1:0] sel;
    begin
      ratio_is_16 = ~sel[0];
    end
  endfunction

  // Bit 1 weighs +1 and bit 0 weighs -1
  function [`SDD_DATA_W-1:0] bit_weight;
    input in_bit;
    begin
      if (in_bit) begin
        bit_weight = `SDD_POS_ONE;
      end else begin
        bit_weight = `SDD_NEG_ONE;
      end
    end
  endfunction

  // Bit count that closes one output period
  function [3:0] last_count;
    input use_r16;
    begin
      if (use_r16) begin
        last_count = `SDD_LAST_R16;
      end else begin
        last_count = `SDD_LAST_R8;
      end
    end
  endfunction

  // Comb tap: previous decimated value at ratio 16, the one before it at ratio 8
  function [`SDD_DATA_W-1:0] comb_tap;
    input use_r16;
    input [`SDD_DATA_W-1:0] tap_one;
    input [`SDD_DATA_W-1:0] tap_two;
    begin
      if (use_r16) begin
        comb_tap = tap_one;
      end else begin
        comb_tap = tap_two;
      end
    end
  endfunction

  wire raw_tick;
  reg [`SDD_SLOT_W-1:0] slot;
  reg [`SDD_SLOT_W-1:0] next_slot;
  reg gated;
  reg next_mod_clk;
  reg bit_stb;
  reg proc_tick;
  wire [1:0] bits_in;
  wire [`SDD_SEL_W-1:0] sel_in [0:1];
  wire [`SDD_DATA_W-1:0] smp [0:1];
  wire vld [0:1];

  assign bits_in = {Y_BITSTREAM, X_BITSTREAM};
  assign sel_in[0] = X_FILTER_SELECT;
  assign sel_in[1] = Y_FILTER_SELECT;

  sdd_tick u_tick (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(raw_tick)
  );

  // Slot sequencer: eight ticks per modulator period
  always @* begin
    next_slot = slot;
    if (raw_tick) begin
      if (slot == `SDD_SLOT_LAST) begin
        next_slot = {`SDD_SLOT_W{1'b0}};
      end else begin
        next_slot = slot + {{(`SDD_SLOT_W-1){1'b0}}, 1'b1};
      end
    end
    // Rising edge at slot 0, falling at slot 4
    next_mod_clk = (next_slot < `SDD_SLOT_FALL);
    // Drop the tick that opens the last processing cycle before either edge,
    // so no datapath switching disturbs the modulator while it settles
    gated = (slot == `SDD_SLOT_GATE_A) || (slot == `SDD_SLOT_GATE_B);
    proc_tick = raw_tick && !gated;
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      slot <= {`SDD_SLOT_W{1'b0}};
      MOD_CLK <= `SDD_RST_MOD_CLK;
      PROC_EN <= 1'b0;
      bit_stb <= 1'b0;
    end else begin
      slot <= next_slot;
      MOD_CLK <= next_mod_clk;
      // Strobes lag the raw tick by one cycle, as MOD_CLK does
      PROC_EN <= proc_tick;
      // One new bit per modulator period, taken in slot 0
      bit_stb <= proc_tick && (slot == `SDD_SLOT_CAPT);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : axis
      // Each axis owns all of its state below
      reg [`SDD_DATA_W-1:0] int1;
      reg [`SDD_DATA_W-1:0] int2;
      reg [`SDD_DATA_W-1:0] int3;
      reg [`SDD_DATA_W-1:0] dly1_a;
      reg [`SDD_DATA_W-1:0] dly1_b;
      reg [`SDD_DATA_W-1:0] dly2_a;
      reg [`SDD_DATA_W-1:0] dly2_b;
      reg [`SDD_DATA_W-1:0] dly3_a;
      reg [`SDD_DATA_W-1:0] dly3_b;
      reg [3:0] cnt;
      reg r16;
      reg [`SDD_DATA_W-1:0] sample;
      reg valid;
      reg [`SDD_DATA_W-1:0] in_val;
      reg [`SDD_DATA_W-1:0] comb1;
      reg [`SDD_DATA_W-1:0] comb2;
      reg [`SDD_DATA_W-1:0] comb3;
      reg fire;

      always @* begin
        in_val = bit_weight(bits_in[g]);
        fire = bit_stb && (cnt == last_count(r16));
        // Comb delay of 1 at ratio 16 and 2 at ratio 8 keeps length 16
        comb1 = int3 - comb_tap(r16, dly1_a, dly1_b);
        comb2 = comb1 - comb_tap(r16, dly2_a, dly2_b);
        comb3 = comb2 - comb_tap(r16, dly3_a, dly3_b);
      end

      // Integrators step once per bit, combs once per output sample
      always @(posedge CLK) begin
        if (!RST_N) begin
          int1 <= `SDD_RST_DATA;
          int2 <= `SDD_RST_DATA;
          int3 <= `SDD_RST_DATA;
          dly1_a <= `SDD_RST_DATA;
          dly1_b <= `SDD_RST_DATA;
          dly2_a <= `SDD_RST_DATA;
          dly2_b <= `SDD_RST_DATA;
          dly3_a <= `SDD_RST_DATA;
          dly3_b <= `SDD_RST_DATA;
          cnt <= `SDD_RST_CNT;
          r16 <= `SDD_RST_R16;
          sample <= `SDD_RST_DATA;
          valid <= 1'b0;
        end else begin
          valid <= fire;
          if (bit_stb) begin
            // Integrators wrap modulo 2^14, which the combs undo
            int1 <= int1 + in_val;
            int2 <= int2 + int1;
            int3 <= int3 + int2;
            if (fire) begin
              cnt <= `SDD_RST_CNT;
              // Ratio changes take effect only at a sample boundary
              r16 <= ratio_is_16(sel_in[g]);
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          if (fire) begin
            dly1_a <= int3;
            dly1_b <= dly1_a;
            dly2_a <= comb1;
            dly2_b <= dly2_a;
            dly3_a <= comb2;
            dly3_b <= dly3_a;
            sample <= comb3;
          end
        end
      end

      assign smp[g] = sample;
      assign vld[g] = valid;
    end
  endgenerate

  assign X_SAMPLE = smp[0];
  assign X_VALID = vld[0];
  assign Y_SAMPLE = smp[1];
  assign Y_VALID = vld[1];

endmodule // sdd_top
`default_nettype wire

// ### pkg/sdd_regs.vh
// Purpose: Shared constants of the two-axis sinc decimator front end
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef SDD_REGS_VH
`define SDD_REGS_VH

// Clock rates in Hz
`define SDD_CLK_HZ 26'h17d7840
`define SDD_PROC_HZ 26'h07a1200
`define SDD_MOD_HZ 26'h00f4240

// Fractional divider accumulator width
`define SDD_ACC_W 26

// Processing slots in one modulator period, and slot fields
`define SDD_SLOTS (`SDD_PROC_HZ / `SDD_MOD_HZ)
`define SDD_SLOT_W 3
`define SDD_SLOT_LAST 3'h7
`define SDD_SLOT_FALL 3'h4
`define SDD_SLOT_CAPT 3'h0
`define SDD_SLOT_GATE_A 3'h2
`define SDD_SLOT_GATE_B 3'h6

// Sinc datapath
`define SDD_DATA_W 14
`define SDD_SEL_W 4
`define SDD_POS_ONE 14'h0001
`define SDD_NEG_ONE 14'h3fff
`define SDD_LAST_R16 4'hf
`define SDD_LAST_R8 4'h7
`define SDD_RST_DATA 14'h0000
`define SDD_RST_CNT 4'h0
`define SDD_RST_R16 1'b1
`define SDD_RST_MOD_CLK 1'b1

`endif

// ### design/sdd_tick.v
// Purpose: Fractional divider making 8 MHz processing ticks from the system clock
// Assumes: Rates from sdd_regs.vh; CLK faster than twice the tick rate
// Notes: Tick is a one-cycle pulse; average rate exact, spacing jitters by one cycle
`timescale 1ns/10ps
`default_nettype none
`include "sdd_regs.vh"

module sdd_tick (
  input wire clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  output reg tick // One-cycle 8 MHz tick
);

  localparam [`SDD_ACC_W-1:0] STEP = `SDD_PROC_HZ;
  localparam [`SDD_ACC_W-1:0] MODULUS = `SDD_CLK_HZ;

  reg [`SDD_ACC_W-1:0] acc;
  reg [`SDD_ACC_W-1:0] next_acc;
  reg next_tick;

  always @* begin
    next_acc = acc + STEP;
    next_tick = 1'b0;
    if (next_acc >= MODULUS) begin
      next_acc = next_acc - MODULUS;
      next_tick = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      acc <= {`SDD_ACC_W{1'b0}};
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tick <= next_tick;
    end
  end

endmodule // sdd_tick
`default_nettype wire

// ### verif/sdd_chk.sv
// Purpose: Port checks of sdd_top
// Assumes: One clock domain
// Notes: Bound below
`timescale 1ns/10ps
`default_nettype none
module sdd_chk (
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic MOD_CLK, // Mod clock
  input wire logic PROC_EN, // Tick
  input wire logic [13:0] X_SAMPLE, // X word
  input wire logic X_VALID, // X strobe
  input wire logic [13:0] Y_SAMPLE, // Y word
  input wire logic Y_VALID // Y strobe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [2:0] ticks;
  logic [8:0] gap;
  logic mseen;
  logic xseen;
  logic yseen;
  logic [8:0] ygap;
  always @(posedge CLK) begin
    mseen <= RST_N && (mseen || $rose(MOD_CLK));
    xseen <= RST_N && (xseen || X_VALID);
    ticks <= (!RST_N || $rose(MOD_CLK)) ? {2'h0, PROC_EN} : ticks + {2'h0, PROC_EN};
    gap <= (!RST_N || X_VALID) ? 9'h000 : gap + 9'h001;
    yseen <= RST_N && (yseen || Y_VALID);
    ygap <= (!RST_N || Y_VALID) ? 9'h000 : ygap + 9'h001;
  end
  sequence mod_rise;
    $rose(MOD_CLK);
  endsequence
  a_mod_period: assert property (mod_rise |-> ##[24:26] mod_rise)
    else $error("mod clock period");
  a_tick_pulse: assert property (PROC_EN |=> !PROC_EN)
    else $error("tick width");
  a_six_ticks: assert property ($rose(MOD_CLK) && mseen |-> ticks == 3'h6)
    else $error("tick count");
  a_gate_edge: assert property ($changed(MOD_CLK) |-> PROC_EN && !$past(PROC_EN) && !$past(PROC_EN, 2) &&
    !$past(PROC_EN, 3) && !$past(PROC_EN, 4) && !$past(PROC_EN, 5))
    else $error("tick before edge");
  a_x_strobe: assert property (X_VALID |=> !X_VALID)
    else $error("x strobe width");
  a_y_strobe: assert property (Y_VALID |=> !Y_VALID)
    else $error("y strobe width");
  a_x_hold: assert property (!X_VALID |-> $stable(X_SAMPLE))
    else $error("x word moved");
  a_y_hold: assert property (!Y_VALID |-> $stable(Y_SAMPLE))
    else $error("y word moved");
  a_x_ratio: assert property (X_VALID && xseen |-> gap == 9'h0c7 || gap == 9'h18f)
    else $error("x spacing");
  a_y_ratio: assert property (Y_VALID && yseen |-> ygap == 9'h0c7 || ygap == 9'h18f)
    else $error("y spacing");
endmodule // sdd_chk
bind sdd_top sdd_chk u_chk (.CLK(CLK), .RST_N(RST_N), .MOD_CLK(MOD_CLK), .PROC_EN(PROC_EN),
  .X_SAMPLE(X_SAMPLE), .X_VALID(X_VALID), .Y_SAMPLE(Y_SAMPLE), .Y_VALID(Y_VALID));
`default_nettype wire

// ### verif/sdd_mod_model.sv
// Purpose: Modulator bit source per axis
// Assumes: Bits move after mod clock falls
// Notes: Constant level per axis
`timescale 1ns/10ps
`default_nettype none
module sdd_mod_model (
  input wire logic clk, // System clock
  input wire logic mod_clk, // Mod clock
  input wire logic [1:0] level, // Y then X level
  output logic x_bit, // X bit
  output logic y_bit // Y bit
);
  logic last;
  initial begin
    x_bit = 1'b0;
    y_bit = 1'b0;
    last = 1'b1;
  end
  always @(posedge clk) begin
    last <= mod_clk;
    if (last && !mod_clk) begin
      x_bit <= level[0];
      y_bit <= level[1];
    end
  end
endmodule // sdd_mod_model
`default_nettype wire

// ### verif/sigma_delta_sinc_decimator_tb.sv
// Purpose: Bench for sdd_top
// Assumes: Full-scale steady bits
// Notes: Filter fill awaited
`timescale 1ns/10ps
`default_nettype none
module sigma_delta_sinc_decimator_tb;
  logic CLK, RST_N, xb, yb, mclk, xv, yv;
  logic [3:0] xsel, ysel;
  logic [1:0] level;
  logic [13:0] xs, ys;
  int errors, cmp_count;
  sdd_top DUT (.CLK(CLK), .RST_N(RST_N), .X_BITSTREAM(xb), .Y_BITSTREAM(yb), .X_FILTER_SELECT(xsel),
    .Y_FILTER_SELECT(ysel), .MOD_CLK(mclk), .PROC_EN(), .X_SAMPLE(xs), .X_VALID(xv),
    .Y_SAMPLE(ys), .Y_VALID(yv));
  sdd_mod_model MOD (.clk(CLK), .mod_clk(mclk), .level(level), .x_bit(xb), .y_bit(yb));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cycles between two strobes of one axis
  task automatic gap(input bit on_y, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (n < 1000 && (on_y ? yv : xv) !== 1'b1);
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (n < 1000 && (on_y ? yv : xv) !== 1'b1);
  endtask
  task automatic run(input logic [3:0] xs_sel, ys_sel, input logic [1:0] lv, input int xg, yg,
    input logic [13:0] xe, ye);
    int n;
    @(posedge CLK);
    xsel <= xs_sel;
    ysel <= ys_sel;
    level <= lv;
    repeat (2500) @(posedge CLK);
    gap(1'b0, n);
    chk("x gap", 14'(xg), 14'(n));
    chk("x sample", xe, xs);
    gap(1'b1, n);
    chk("y gap", 14'(yg), 14'(n));
    chk("y sample", ye, ys);
  endtask
  task automatic t_x_up_y_down();
    run(4'h0, 4'h3, 2'b01, 400, 200, 14'h1000, 14'h3000);
  endtask
  task automatic t_x_down_y_up();
    run(4'h5, 4'ha, 2'b10, 200, 400, 14'h3000, 14'h1000);
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    print_verdict();
  end
  initial begin
    RST_N = 1'b0;
    xsel = 4'h0;
    ysel = 4'h0;
    level = 2'b00;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    t_x_up_y_down();
    t_x_down_y_up();
    print_verdict();
  end
endmodule // sigma_delta_sinc_decimator_tb
`default_nettype wire
